// ===== hw/supervisor_pkg.sv
// Constants for the regulator supervisor, watchdog and hold control
// Functional notes
// - Reset low below threshold, stretched 200ms
// - Threshold option 7.5 or 12.5 percent
// - Watchdog idle 1.6s asserts reset
// - Idle watchdog gives 200ms low, 1.6s high
// - Reset held full timeout, kicks ignored
// - Kick or reset clears watchdog counter
// - Counter stopped during reset, restarts after
// - Enable high turns regulator on
// - Hold low keeps output on
// - Hold released with enable low shuts down
// - Hold high follows enable alone
// - Over-temperature forces off, hysteresis restarts
// - Undriven inputs give off state
// - Reset output open-drain active low
package supervisor_pkg;
  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned RESET_STRETCH_MS  = 200;
  localparam int unsigned WD_TIMEOUT_MS     = 1600;
  localparam int unsigned WD_KICK_MIN_MS    = 1120;
  // Cycles per interval: ms times kHz
  localparam int unsigned RESET_STRETCH_CYC = RESET_STRETCH_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_TIMEOUT_CYC    = WD_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W             = 28;
  // Threshold option codes
  localparam logic        THRESH_7P5        = 1'b0;
  localparam logic        THRESH_12P5       = 1'b1;
  // Safe pin values while unsynchronised at reset
  localparam logic        ENABLE_RST        = 1'b0;
  localparam logic        HOLD_N_RST        = 1'b1;
  localparam logic        KICK_RST          = 1'b0;
  typedef enum logic [1:0] {
    SUP_RUN     = 2'b00,
    SUP_STRETCH = 2'b01,
    SUP_LOW     = 2'b10
  } sup_state_t;
  typedef enum logic [1:0] {
    REG_OFF  = 2'b00,
    REG_ON   = 2'b01,
    REG_HELD = 2'b10
  } reg_state_t;
endpackage

// ===== hw/sync_bit.sv
// Two-flop synchroniser for one input level
`timescale 1ns/1ps
module sync_bit #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,   // Clock
  input  wire logic rstn,  // Async reset, active low
  input  wire logic d,     // Asynchronous level
  output logic      q      // Synchronised level
);
  logic meta;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // sync_bit

// ===== hw/supervisor_watchdog_hold_control.sv
// Reset supervisor, watchdog and enable/hold regulator control
`timescale 1ns/1ps
module supervisor_watchdog_hold_control #(
  parameter int unsigned RESET_STRETCH_CYC = supervisor_pkg::RESET_STRETCH_CYC,
  parameter int unsigned WD_TIMEOUT_CYC    = supervisor_pkg::WD_TIMEOUT_CYC,
  parameter logic        WATCHDOG_PRESENT  = 1'b1
) (
  input  wire logic clk,                  // 100 MHz timebase
  input  wire logic rstn,                 // Async reset, active low
  input  wire logic thresh_sel,           // Threshold option, 0: 7.5%, 1: 12.5%
  input  wire logic out_below_7p5,        // Comparator: output below -7.5% trip
  input  wire logic out_below_12p5,       // Comparator: output below -12.5% trip
  input  wire logic watchdog_kick_input,  // Processor kick pin
  input  wire logic enable,               // Enable pin, active high
  input  wire logic hold_n,               // Self-hold pin, active low
  input  wire logic over_temp,            // Thermal flag, hysteresis in sensor
  output logic      reg_on,               // Regulator pass device on
  output logic      reset_n_out,          // Reset pad output value (always 0)
  output logic      reset_n_oe_n,         // Reset pad enable, low pulls line low
  output logic      reset_active          // Internal reset asserted
);
  supervisor_pkg::sup_state_t sup_state;
  supervisor_pkg::reg_state_t reg_state;
  // Interval counters, wide enough for the full watchdog span
  logic [supervisor_pkg::CNT_W-1:0] stretch_cnt;
  logic [supervisor_pkg::CNT_W-1:0] wd_cnt;
  // Pin levels after the synchronisers
  logic kick_s;
  logic kick_d;
  logic en_s;
  logic hold_n_s;
  // Decoded conditions
  logic below;
  logic kick_edge;
  logic wd_expire;
  logic stretch_done;

  sync_bit #(.RST_VAL(supervisor_pkg::KICK_RST)) u_sync_kick (
    .clk (clk),
    .rstn(rstn),
    .d   (watchdog_kick_input),
    .q   (kick_s)
  );

  sync_bit #(.RST_VAL(supervisor_pkg::ENABLE_RST)) u_sync_en (
    .clk (clk),
    .rstn(rstn),
    .d   (enable),
    .q   (en_s)
  );

  // Hold idles high, as its pull-up would leave it
  sync_bit #(.RST_VAL(supervisor_pkg::HOLD_N_RST)) u_sync_hold (
    .clk (clk),
    .rstn(rstn),
    .d   (hold_n),
    .q   (hold_n_s)
  );

  // Delayed copy for edge detect; resets to the pin's idle level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      kick_d <= supervisor_pkg::KICK_RST;
    end else begin
      kick_d <= kick_s;
    end
  end

  assign below = (thresh_sel == supervisor_pkg::THRESH_12P5) ? out_below_12p5
                                                              : out_below_7p5;
  // any change of the synchronised level is a kick
  assign kick_edge = kick_s ^ kick_d;
  assign wd_expire = WATCHDOG_PRESENT &&
                     (wd_cnt == supervisor_pkg::CNT_W'(WD_TIMEOUT_CYC - 1));
  assign stretch_done = (stretch_cnt ==
                         supervisor_pkg::CNT_W'(RESET_STRETCH_CYC - 1));

  // Reset sequencing; starts asserted so power-up stretches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sup_state <= supervisor_pkg::SUP_LOW;
    end else begin
      unique case (sup_state)
        supervisor_pkg::SUP_RUN: begin
          if (below) begin
            sup_state <= supervisor_pkg::SUP_LOW;
          end else if (wd_expire) begin
            sup_state <= supervisor_pkg::SUP_STRETCH;
          end
        end
        supervisor_pkg::SUP_LOW: begin
          if (!below) begin
            sup_state <= supervisor_pkg::SUP_STRETCH;
          end
        end
        supervisor_pkg::SUP_STRETCH: begin
          if (below) begin
            sup_state <= supervisor_pkg::SUP_LOW;
          end else if (stretch_done) begin
            sup_state <= supervisor_pkg::SUP_RUN;
          end
        end
        default: begin
          sup_state <= supervisor_pkg::SUP_LOW;
        end
      endcase
    end
  end

  // stretch timer, only runs in the stretch state
  // A dip during the stretch starts the whole interval over
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stretch_cnt <= '0;
    end else if (sup_state != supervisor_pkg::SUP_STRETCH) begin
      stretch_cnt <= '0;
    end else if (below || stretch_done) begin
      stretch_cnt <= '0;
    end else begin
      stretch_cnt <= stretch_cnt + 1'b1;
    end
  end

  // Watchdog counter; idle without a watchdog so it never wraps needlessly
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wd_cnt <= '0;
    end else if (!WATCHDOG_PRESENT) begin
      wd_cnt <= '0;
    end else if (sup_state != supervisor_pkg::SUP_RUN || wd_expire) begin
      wd_cnt <= '0;
    end else if (kick_edge) begin
      wd_cnt <= '0;
    end else begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // Regulator enable/hold state machine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_state <= supervisor_pkg::REG_OFF;
    end else begin
      unique case (reg_state)
        supervisor_pkg::REG_OFF: begin
          if (en_s && hold_n_s) begin
            reg_state <= supervisor_pkg::REG_ON;
          // Hold already low: latch straight into the held state
          end else if (en_s) begin
            reg_state <= supervisor_pkg::REG_HELD;
          end
        end
        supervisor_pkg::REG_ON: begin
          // hold pulled low while on latches
          if (!hold_n_s) begin
            reg_state <= supervisor_pkg::REG_HELD;
          end else if (!en_s) begin
            reg_state <= supervisor_pkg::REG_OFF;
          end
        end
        supervisor_pkg::REG_HELD: begin
          if (hold_n_s && en_s) begin
            reg_state <= supervisor_pkg::REG_ON;
          end else if (hold_n_s) begin
            reg_state <= supervisor_pkg::REG_OFF;
          end
        end
        default: begin
          reg_state <= supervisor_pkg::REG_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_on <= 1'b0;
    end else begin
      reg_on <= (reg_state != supervisor_pkg::REG_OFF) && !over_temp;
    end
  end

  // open-drain, only ever pulls low
  // Registered so the pad never glitches low on a state change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reset_n_oe_n <= 1'b0;
    end else begin
      reset_n_oe_n <= (sup_state == supervisor_pkg::SUP_RUN) ? 1'b1 : 1'b0;
    end
  end

  // Internal view of the same reset, for logic beside the pad
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reset_active <= 1'b1;
    end else begin
      reset_active <= (sup_state != supervisor_pkg::SUP_RUN);
    end
  end

  // pad data is tied low; only the enable moves
  assign reset_n_out = 1'b0;
endmodule // supervisor_watchdog_hold_control

// ===== verif/supervisor_checker.sv
// Port checker for the regulator supervisor
`timescale 1ns/1ps
module supervisor_checker #(
  parameter int unsigned RESET_STRETCH_CYC = 20,
  parameter int unsigned WD_TIMEOUT_CYC    = 100
) (
  input wire logic clk,                  // Clock
  input wire logic rstn,                 // Async reset, active low
  input wire logic thresh_sel,           // Threshold option
  input wire logic out_below_7p5,        // Comparator, -7.5% trip
  input wire logic out_below_12p5,       // Comparator, -12.5% trip
  input wire logic watchdog_kick_input,  // Kick pin
  input wire logic enable,               // Enable pin
  input wire logic hold_n,               // Self-hold pin, active low
  input wire logic over_temp,            // Thermal flag
  input wire logic reg_on,               // Regulator on
  input wire logic reset_n_out,          // Reset pad data
  input wire logic reset_n_oe_n,         // Reset pad enable, active low
  input wire logic reset_active          // Reset asserted
);
  wire         b = thresh_sel ? out_below_12p5 : out_below_7p5;
  logic        kick_q;
  int unsigned run_cnt;
  int unsigned idle_cnt;
  // Pin edges lead the design's synchronised view, so idle_cnt never lags after a kick; it starts a cycle late at reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      kick_q   <= 1'b0;
      run_cnt  <= 0;
      idle_cnt <= 0;
    end else begin
      kick_q   <= watchdog_kick_input;
      run_cnt  <= reset_active ? run_cnt + 1 : 0;
      idle_cnt <= (reset_active || watchdog_kick_input != kick_q) ? 0 : idle_cnt + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  pad_drain_a: assert property (!reset_n_out && reset_n_oe_n != reset_active)
    else $error("reset pad misdriven");
  brown_rst_a: assert property (b |-> ##2 reset_active) else $error("no brownout reset");
  stretch_len_a: assert property ($fell(reset_active) |->
    run_cnt >= RESET_STRETCH_CYC - 1 && !$past(b)) else $error("reset too short");
  wd_cause_a: assert property ($rose(reset_active) |->
    $past(b, 2) || idle_cnt >= WD_TIMEOUT_CYC - 4) else $error("early reset");
  en_on_a: assert property ((enable && !over_temp)[*5] |=> reg_on) else $error("enable lost");
  hot_off_a: assert property (over_temp |=> !reg_on) else $error("hot but on");
  hold_on_a: assert property ((!hold_n)[*4] ##0 (reg_on && !over_temp) |=> reg_on)
    else $error("hold dropped");
  off_a: assert property ((!enable && hold_n)[*5] |=> !reg_on) else $error("not off");
  cover property ($rose(reset_active) && !$past(b, 2));
  cover property (!enable && !hold_n && reg_on);
  cover property (over_temp ##1 !reg_on);
endmodule // supervisor_checker
bind supervisor_watchdog_hold_control supervisor_checker #(
  .RESET_STRETCH_CYC(RESET_STRETCH_CYC), .WD_TIMEOUT_CYC(WD_TIMEOUT_CYC)) chk (.clk, .rstn,
  .thresh_sel, .out_below_7p5, .out_below_12p5, .watchdog_kick_input, .enable, .hold_n,
  .over_temp, .reg_on, .reset_n_out, .reset_n_oe_n, .reset_active);

// ===== verif/cpu_model.sv
// Processor model that toggles the watchdog kick pin
`timescale 1ns/1ps
module cpu_model (
  input  wire logic       clk,         // Clock
  input  wire logic       reset_line,  // Open-drain reset net
  input  wire logic       kick_en,     // Software alive
  input  wire logic [7:0] period,      // Cycles between kicks, less one
  output logic            kick         // Kick pin
);
  logic [7:0] cnt  = 8'h00;
  logic       rl_q = 1'b1;
  initial kick = 1'b0;
  // timely kick edges, restarted at reset release
  always @(posedge clk) begin
    rl_q <= reset_line;
    if (!kick_en || cnt == period || (reset_line && !rl_q)) cnt <= 8'h00;
    else cnt <= cnt + 8'h01;
    if (kick_en && cnt == period) kick <= #1 !kick;
  end
endmodule // cpu_model

// ===== verif/tb_top.sv
// Self-checking bench for the regulator supervisor
`timescale 1ns/1ps
module tb_top;
  localparam int N  = 20;
  localparam int WD = 100;
  // Idle enable and hold_n levels stand for the internal pulls
  logic       clk = 1'b0, rstn = 1'b0, thresh_sel = 1'b0, b75 = 1'b0, b125 = 1'b0;
  logic       enable = 1'b0, hold_n = 1'b1, over_temp = 1'b0, kick_en = 1'b1;
  logic [7:0] period = 8'h28;
  logic       kick, reg_on, rst_o, rst_oe_n, reset_active;
  wire        reset_line = rst_oe_n ? 1'b1 : rst_o;
  int         error_cnt = 0, checks = 0, d;
  initial forever #5 clk = ~clk;
  supervisor_watchdog_hold_control #(.RESET_STRETCH_CYC(N), .WD_TIMEOUT_CYC(WD)) dut (
    .clk, .rstn, .thresh_sel, .out_below_7p5(b75), .out_below_12p5(b125),
    .watchdog_kick_input(kick), .enable, .hold_n, .over_temp, .reg_on,
    .reset_n_out(rst_o), .reset_n_oe_n(rst_oe_n), .reset_active);
  cpu_model cpu (.clk, .reset_line, .kick_en, .period, .kick);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic dur(input logic lv);
    d = 0;
    while (reset_active === lv && d < 1000) begin
      cyc(1);
      d++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset;
    chk("por_rst", reset_line, 1'b0);
    dur(1'b1);
    chk("por_len", d >= N && d <= N + 2, 1'b1);
    chk("released", reset_line, 1'b1);
    for (int s = 0; s < 2; s++) begin
      thresh_sel = s[0];
      {b125, b75} = s[0] ? 2'b01 : 2'b10;
      cyc(6);
      chk("other_trip", reset_active, 1'b0);
      {b125, b75} = 2'b11;
      cyc(6);
      chk("brownout", reset_active, 1'b1);
      {b125, b75} = 2'b00;
      dur(1'b1);
      chk("brown_len", d >= N && d <= N + 2, 1'b1);
    end
    $display("t_reset done");
  endtask
  task automatic t_reg;
    chk("idle_off", reg_on, 1'b0);
    enable = 1'b1;
    cyc(6);
    chk("en_on", reg_on, 1'b1);
    hold_n = 1'b0;
    cyc(6);
    enable = 1'b0;
    cyc(6);
    chk("held", reg_on, 1'b1);
    over_temp = 1'b1;
    cyc(2);
    chk("hot", reg_on, 1'b0);
    over_temp = 1'b0;
    cyc(2);
    chk("cool", reg_on, 1'b1);
    hold_n = 1'b1;
    cyc(6);
    chk("shutdown", reg_on, 1'b0);
    enable = 1'b1;
    cyc(6);
    chk("plain_on", reg_on, 1'b1);
    enable = 1'b0;
    cyc(6);
    chk("plain_off", reg_on, 1'b0);
    $display("t_reg done");
  endtask
  task automatic t_wd;
    kick_en = 1'b0;
    dur(1'b0);
    dur(1'b1);
    chk("wd_low", d >= N - 1 && d <= N + 2, 1'b1);
    dur(1'b0);
    chk("wd_high", d >= WD - 1 && d <= WD + 3, 1'b1);
    period = 8'h03;
    kick_en = 1'b1;
    dur(1'b1);
    chk("kick_ignored", d >= N - 1 && d <= N + 2, 1'b1);
    period = 8'h28;
    cyc(300);
    chk("kicked", reset_active, 1'b0);
    $display("t_wd done");
  endtask
  initial begin
    #100000;
    error_cnt++;
    finish_test;
  end
  initial begin
    cyc(12);
    rstn = 1'b1;
    t_reset;
    t_reg;
    t_wd;
    rstn = 1'b0;
    cyc(2);
    chk("rst_again", reset_active, 1'b1);
    rstn = 1'b1;
    dur(1'b1);
    chk("por_again", d >= N && d <= N + 2, 1'b1);
    finish_test;
  end
endmodule // tb_top
